// File: logic/fbg_baud_gen.sv
// Fractional baud rate generator with legacy timer baud source selection
`timescale 1ns/10ps
module fbg_baud_gen (
    input wire logic mclk, // Core clock, 10 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [0:0] regAddr, // Register address
    input wire logic [7:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [7:0] regRdata, // Read data, cycle after strobe
    input wire logic [1:0] uartMode, // UART mode select
    input wire logic baudDoublingBit, // Doubling bit of power control
    input wire logic txTimerTwoSelect, // Timer two drives transmit
    input wire logic rxTimerTwoSelect, // Timer two drives receive
    input wire logic timerOneOvf, // Timer one overflow pulse
    input wire logic timerTwoOvf, // Timer two overflow pulse
    output logic txSampleTick, // Transmit 16x tick pulse
    output logic rxSampleTick // Receive 16x tick pulse
);
    import fbg_pkg::*;

    logic [7:0] baudTimerControl_ff;
    logic [7:0] fractionalDivideValue_ff;
    logic [7:0] regRdata_ff;
    logic [PRE_WIDTH-1:0] preCnt_ff;
    logic [CNT_WIDTH-1:0] fracAcc_ff;
    logic smodPhase_ff;
    logic txTick_ff;
    logic rxTick_ff;
    logic baudGeneratorEnable;
    logic [2:0] prescaleSel;
    logic preTick;
    logic genTick;
    logic varMode;
    logic t1Tick;
    logic [CNT_WIDTH-1:0] modulus;
    logic [CNT_WIDTH-1:0] accSum;
    logic accWraps;

    // Modulus of the fractional accumulator: divide value plus 64
    function automatic logic [CNT_WIDTH-1:0] tick_modulus(input logic [7:0] fd);
        return CNT_WIDTH'(fd) + CNT_WIDTH'(FRAC_OFFSET);
    endfunction : tick_modulus

    // Accumulator after one prescaled pulse; 32 per modulus gives 16 ticks per bit
    function automatic logic [CNT_WIDTH-1:0] acc_step(input logic [CNT_WIDTH-1:0] acc);
        return acc + ACC_STEP;
    endfunction : acc_step

    // Control field decode
    assign baudGeneratorEnable = baudTimerControl_ff[ENABLE_POS];
    assign prescaleSel = baudTimerControl_ff[DIV_MSB:0];
    assign modulus = tick_modulus(fractionalDivideValue_ff);
    assign accSum = acc_step(fracAcc_ff);
    assign accWraps = (accSum >= modulus);
    assign varMode = (uartMode == MODE_VAR8) || (uartMode == MODE_VAR9);

    // Register writes, unused control bits dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            baudTimerControl_ff <= CTRL_RESET;
            fractionalDivideValue_ff <= FRAC_RESET;
        end else if (regWr) begin
            if (regAddr == ADDR_CTRL) begin
                baudTimerControl_ff <= {regWdata[ENABLE_POS], 4'h0, regWdata[DIV_MSB:0]};
            end else begin
                fractionalDivideValue_ff <= regWdata;
            end
        end
    end

    // Read data, valid in the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdata_ff <= 8'h00;
        end else if (regRd) begin
            regRdata_ff <= (regAddr == ADDR_CTRL) ? baudTimerControl_ff : fractionalDivideValue_ff;
        end else begin
            regRdata_ff <= 8'h00;
        end
    end
    assign regRdata = regRdata_ff;

    // Free running binary prescaler, own counter apart from timers
    always_ff @(posedge mclk) begin
        if (rst) begin
            preCnt_ff <= '0;
        end else begin
            preCnt_ff <= preCnt_ff + 1'b1;
        end
    end
    // Pulse once per 2^select core clocks
    assign preTick = ((preCnt_ff & PRE_WIDTH'((1 << prescaleSel) - 1)) == PRE_WIDTH'((1 << prescaleSel) - 1));

    // Fractional divider; the remainder is kept on each wrap, so no cumulative drift
    always_ff @(posedge mclk) begin
        if (rst) begin
            fracAcc_ff <= '0;
        end else if (preTick) begin
            if (accWraps) begin
                fracAcc_ff <= accSum - modulus;
            end else begin
                fracAcc_ff <= accSum;
            end
        end
    end
    assign genTick = preTick && accWraps;

    // Timer one: every overflow with doubling, every second without
    always_ff @(posedge mclk) begin
        if (rst) begin
            smodPhase_ff <= 1'b0;
        end else if (timerOneOvf) begin
            smodPhase_ff <= ~smodPhase_ff;
        end
    end
    assign t1Tick = timerOneOvf && (baudDoublingBit || smodPhase_ff);

    // Source selection per direction, variable modes only
    always_ff @(posedge mclk) begin
        if (rst) begin
            txTick_ff <= 1'b0;
            rxTick_ff <= 1'b0;
        end else if (!varMode) begin
            txTick_ff <= 1'b0;
            rxTick_ff <= 1'b0;
        end else if (baudGeneratorEnable) begin
            txTick_ff <= genTick;
            rxTick_ff <= genTick;
        end else begin
            txTick_ff <= txTimerTwoSelect ? timerTwoOvf : t1Tick;
            rxTick_ff <= rxTimerTwoSelect ? timerTwoOvf : t1Tick;
        end
    end
    assign txSampleTick = txTick_ff;
    assign rxSampleTick = rxTick_ff;

    // Checks, all on the core clock and its reset
    sequence genEvent;
        varMode && baudGeneratorEnable && genTick;
    endsequence
    sequence bothTicks;
        txSampleTick && rxSampleTick;
    endsequence
    sequence noTicks;
        !txSampleTick && !rxSampleTick;
    endsequence
    sequence ctrlRead;
        regRd && (regAddr == ADDR_CTRL);
    endsequence

    // Generator tick reaches both directions one cycle later
    gen_source_a: assert property (@(posedge mclk) disable iff (rst) genEvent |=> bothTicks)
        else $error("generator tick not forwarded");

    // Between generator ticks nothing from the timers leaks through
    legacy_ignored_a: assert property (@(posedge mclk) disable iff (rst)
        (varMode && baudGeneratorEnable && !genTick) |=> noTicks)
        else $error("legacy source leaked while enabled");

    // Timer one with doubling ticks on every overflow
    baud_doubling_bit_timer1_a: assert property (@(posedge mclk) disable iff (rst)
        (varMode && !baudGeneratorEnable && !txTimerTwoSelect && timerOneOvf && baudDoublingBit) |=> txSampleTick)
        else $error("timer one tick missing");

    // Timer one without doubling skips every other overflow
    baud_doubling_bit_half_a: assert property (@(posedge mclk) disable iff (rst)
        (varMode && !baudGeneratorEnable && !txTimerTwoSelect && timerOneOvf && !baudDoublingBit && !smodPhase_ff)
        |=> !txSampleTick)
        else $error("timer one tick without halving");

    // Receive side follows timer one when timer two is not selected
    rx_timer1_a: assert property (@(posedge mclk) disable iff (rst)
        (varMode && !baudGeneratorEnable && !rxTimerTwoSelect && t1Tick) |=> rxSampleTick)
        else $error("receive timer one tick missing");

    // Receive side on timer two ticks only on its overflow
    timer2_dir_a: assert property (@(posedge mclk) disable iff (rst)
        (varMode && !baudGeneratorEnable && rxTimerTwoSelect && !timerTwoOvf) |=> !rxSampleTick)
        else $error("receive tick without timer two overflow");

    // Fixed rate modes get no ticks at all
    fixed_mode_a: assert property (@(posedge mclk) disable iff (rst)
        !varMode |=> noTicks)
        else $error("tick in fixed rate mode");

    // Prescale of one pulses on every cycle
    prescale_one_a: assert property (@(posedge mclk) disable iff (rst)
        (prescaleSel == 3'h0) |-> preTick)
        else $error("prescale of one skipped a cycle");

    // Prescale of two never pulses twice in a row
    prescale_gap_a: assert property (@(posedge mclk) disable iff (rst)
        (prescaleSel == 3'h1 && $past(prescaleSel) == 3'h1 && preTick) |-> !$past(preTick))
        else $error("prescale of two wrong spacing");

    // Prescale of two never pauses two cycles
    prescale_alt_a: assert property (@(posedge mclk) disable iff (rst)
        (prescaleSel == 3'h1 && $past(prescaleSel) == 3'h1 && !preTick) |-> $past(preTick))
        else $error("prescale of two missed a pulse");

    // A wrap leaves only the remainder below one step
    frac_wrap_a: assert property (@(posedge mclk) disable iff (rst)
        (genTick && fracAcc_ff < modulus) |=> fracAcc_ff < ACC_STEP)
        else $error("divider did not wrap");

    // Accumulator only moves on prescaled pulses
    acc_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !preTick |=> $stable(fracAcc_ff))
        else $error("accumulator moved without prescaled pulse");

    // Accumulator stays inside its modulus while the divide value is kept
    acc_bound_a: assert property (@(posedge mclk) disable iff (rst)
        (fracAcc_ff < modulus && !(regWr && regAddr == ADDR_FRAC)) |=> fracAcc_ff < modulus)
        else $error("accumulator out of range");

    // Step below modulus: never two generator ticks back to back
    gen_spacing_a: assert property (@(posedge mclk) disable iff (rst)
        (genTick && fracAcc_ff < modulus) |=> !genTick)
        else $error("generator ticks back to back");

    // Unused control bits read as zero
    unused_bits_a: assert property (@(posedge mclk) disable iff (rst)
        ctrlRead |=> regRdata[6:3] == 4'h0)
        else $error("unused control bits not zero");

    // Read data is zero outside the cycle after a read
    read_idle_a: assert property (@(posedge mclk) disable iff (rst)
        !regRd |=> regRdata == 8'h00)
        else $error("read data outside read cycle");

    // Control read returns the register as it stood at the strobe
    read_ctrl_a: assert property (@(posedge mclk) disable iff (rst)
        ctrlRead |=> regRdata == $past(baudTimerControl_ff))
        else $error("control read data wrong");

    // Writes never set the unused control bits
    ctrl_write_a: assert property (@(posedge mclk) disable iff (rst)
        (regWr && regAddr == ADDR_CTRL) |=> baudTimerControl_ff[6:3] == 4'h0)
        else $error("unused control bits stored");
endmodule : fbg_baud_gen

// File: logic/fbg_pkg.sv
// Constants for the fractional baud rate generator
// Function
// - Enable bit seven set: UART baud ticks come from this generator, not timers.
// - While enabled, doubling bit and timer two clock selects are ignored.
// - Enable clear: legacy timer one or timer two overflow scheme sets rate.
// - Low three control bits select core clock prescale of two to that power.
// - Bit rate equals twice core clock over prescale times divide value plus 64.
// - Every rate from 12 to 393216 bit/s reachable within 0.8 percent; here, at the 10 MHz core clock, only about 490 to 312500 bit/s.
// - Generator is its own counter, independent of timers zero, one and two.
// - Only variable-rate modes one and three use the selected baud source.
// - Legacy timer two select bits give timer two baud mode per direction.
package fbg_pkg;
    localparam logic [0:0] ADDR_CTRL = 1'h0;
    localparam logic [0:0] ADDR_FRAC = 1'h1;
    localparam int ENABLE_POS = 7;
    localparam int DIV_MSB = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FRAC_RESET = 8'h00;
    localparam logic [7:0] FRAC_OFFSET = 8'h40;
    localparam logic [11:0] ACC_STEP = 12'h020;
    localparam logic [1:0] MODE_VAR8 = 2'h1;
    localparam logic [1:0] MODE_VAR9 = 2'h3;
    localparam int PRE_WIDTH = 7;
    localparam int CNT_WIDTH = 12;
endpackage : fbg_pkg

// File: test/fbg_uart_model.sv
// Monitor of the 16x ticks: spacing per direction and transmit tick count
`timescale 1ns/10ps
module fbg_uart_model (
    input wire logic mclk, // Core clock
    input wire logic rst, // Synchronous reset
    input wire logic txSampleTick, // Transmit tick
    input wire logic rxSampleTick, // Receive tick
    output logic [15:0] txGap, // Cycles between transmit ticks
    output logic [15:0] rxGap, // Cycles between receive ticks
    output logic [15:0] txCount // Transmit ticks seen
);
    logic [15:0] txAge;
    logic [15:0] rxAge;
    // Spacing of ticks, sixteen of them per bit
    always_ff @(posedge mclk) begin
        if (rst) begin
            {txAge, rxAge, txGap, rxGap, txCount} <= '0;
        end else begin
            txAge <= txSampleTick ? 16'h0000 : txAge + 16'h0001;
            rxAge <= rxSampleTick ? 16'h0000 : rxAge + 16'h0001;
            if (txSampleTick) txGap <= txAge + 16'h0001;
            if (rxSampleTick) rxGap <= rxAge + 16'h0001;
            if (txSampleTick) txCount <= txCount + 16'h0001;
        end
    end
endmodule : fbg_uart_model

// File: test/fbg_baud_gen_test.sv
// Self-checking bench of the baud rate generator
`timescale 1ns/10ps
module fbg_baud_gen_test;
    import fbg_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, baudDoublingBit = 1'b0;
    logic txTimerTwoSelect = 1'b0, rxTimerTwoSelect = 1'b0, timerOneOvf = 1'b0, timerTwoOvf = 1'b0;
    logic [0:0] regAddr = 1'h0;
    logic [7:0] regWdata = 8'h00, regRdata, ovfCnt = 8'h00, rd;
    logic [1:0] uartMode = 2'h1;
    logic txSampleTick, rxSampleTick;
    logic [15:0] txGap, rxGap, txCount, seenCount;
    int nMismatch = 0, compares = 0, cycles = 0;
    fbg_baud_gen fbg_baud_gen_inst (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .uartMode(uartMode),
        .baudDoublingBit(baudDoublingBit), .txTimerTwoSelect(txTimerTwoSelect),
        .rxTimerTwoSelect(rxTimerTwoSelect), .timerOneOvf(timerOneOvf), .timerTwoOvf(timerTwoOvf),
        .txSampleTick(txSampleTick), .rxSampleTick(rxSampleTick));
    fbg_uart_model fbg_uart_model_inst (.mclk(mclk), .rst(rst), .txSampleTick(txSampleTick),
        .rxSampleTick(rxSampleTick), .txGap(txGap), .rxGap(rxGap), .txCount(txCount));
    always #50 mclk = ~mclk;
    // Timer overflows every 10 and every 7 cycles, plus hang limit
    always @(posedge mclk) begin
        ovfCnt <= (ovfCnt == 8'h45) ? 8'h00 : ovfCnt + 8'h01;
        timerOneOvf <= (ovfCnt % 10 == 9);
        timerTwoOvf <= (ovfCnt % 7 == 6);
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            stop_test();
        end
    end
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task reg_write(input logic [0:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [0:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : reg_read
    task test_regs;
        reg_read(ADDR_CTRL, rd); check("ctrl reset", {8'h00, rd}, 16'h0000);
        reg_read(ADDR_FRAC, rd); check("frac reset", {8'h00, rd}, 16'h0000);
        reg_write(ADDR_CTRL, 8'hff);
        reg_read(ADDR_CTRL, rd); check("ctrl unused bits", {8'h00, rd}, 16'h0087);
        reg_write(ADDR_FRAC, 8'ha5);
        reg_read(ADDR_FRAC, rd); check("frac value", {8'h00, rd}, 16'h00a5);
    endtask : test_regs
    // Settings chosen per prescale and divide formulas legacy inputs busy meanwhile
    task gen_case(input logic [7:0] ctrl, input logic [7:0] fd, input logic [1:0] mode);
        logic [15:0] exp;
        exp = ((16'h0001 << ctrl[2:0]) * ({8'h00, fd} + 16'h0040)) >> 5;
        reg_write(ADDR_FRAC, fd);
        reg_write(ADDR_CTRL, ctrl);
        uartMode <= mode; baudDoublingBit <= ~fd[3]; txTimerTwoSelect <= 1'b1; rxTimerTwoSelect <= fd[5];
        repeat (3 * exp + 40) @(posedge mclk);
        check("gen tx period", txGap, exp);
        check("gen rx period", rxGap, exp);
    endtask : gen_case
    // Fractional ratio: exactly 320 ticks in 1040 cycles, no drift
    task frac_case;
        reg_write(ADDR_FRAC, 8'h28);
        reg_write(ADDR_CTRL, 8'h80);
        repeat (40) @(posedge mclk);
        seenCount = txCount;
        repeat (1040) @(posedge mclk);
        check("frac tick count", txCount - seenCount, 16'd320);
    endtask : frac_case
    task test_fixed_modes;
        for (int m = 0; m < 4; m += 2) begin
            @(posedge mclk) uartMode <= m[1:0];
            repeat (4) @(posedge mclk);
            seenCount = txCount;
            repeat (300) @(posedge mclk);
            check("fixed mode ticks", txCount, seenCount);
        end
    endtask : test_fixed_modes
    task leg_case(input logic dbl, input logic ts, input logic rs, input logic [15:0] etx, input logic [15:0] erx);
        @(posedge mclk);
        uartMode <= MODE_VAR9; baudDoublingBit <= dbl; txTimerTwoSelect <= ts; rxTimerTwoSelect <= rs;
        repeat (100) @(posedge mclk);
        check("legacy tx period", txGap, etx);
        check("legacy rx period", rxGap, erx);
    endtask : leg_case
    task stop_test;
        if (nMismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        test_regs();
        gen_case(8'h81, 8'h20, MODE_VAR8);
        gen_case(8'h85, 8'h00, MODE_VAR9);
        gen_case(8'h82, 8'h00, MODE_VAR9);
        gen_case(8'h80, 8'h20, MODE_VAR8);
        frac_case();
        test_fixed_modes();
        reg_write(ADDR_CTRL, 8'h00);
        leg_case(1'b1, 1'b0, 1'b0, 16'd10, 16'd10);
        leg_case(1'b0, 1'b1, 1'b0, 16'd7, 16'd20);
        leg_case(1'b0, 1'b0, 1'b1, 16'd20, 16'd7);
        stop_test();
    end
endmodule : fbg_baud_gen_test
